// ### logic/vir_pkg.sv
package vir_pkg;

    localparam logic [7:0] VBASE_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hffff;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] MODE_TABLE = 2'h2;
    localparam logic [15:0] MODE1_TARGET = 16'h0038;

    // Cycle budget of the table response
    localparam int VEC_FETCH_CYCLES = 7;
    localparam int SAVE_PC_CYCLES = 6;
    localparam int READ_ADDR_CYCLES = 6;
    localparam int TOTAL_CYCLES = VEC_FETCH_CYCLES + SAVE_PC_CYCLES + READ_ADDR_CYCLES;
    // Wait states inside the acknowledge fetch, and the cycle where the vector is sampled
    localparam int ACK_WAIT_STATES = 2;
    localparam logic [4:0] VEC_SAMPLE_CNT = 5'h05;
    // Cycle offsets (counted from 0 at acceptance) of each memory transfer
    localparam logic [4:0] PUSH_HI_CNT = 5'h09;
    localparam logic [4:0] PUSH_LO_CNT = 5'h0c;
    localparam logic [4:0] READ_LO_CNT = 5'h0f;
    localparam logic [4:0] READ_HI_CNT = 5'h12;
    localparam logic [4:0] LAST_CNT = 5'h12;

    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } vir_mem_s;

    typedef struct packed {
        logic load_base;
        logic [7:0] base_value;
        logic enable_int;
        logic disable_int;
        logic [1:0] mode;
        logic mode_load;
        logic pc_load;
        logic [15:0] pc_value;
    } vir_ctl_s;

endpackage : vir_pkg

// ### logic/vir_response.sv
`timescale 1ns/1ps
module vir_response (
    input wire logic clock,
    input wire logic rst,
    input wire logic int_req,
    input wire logic insn_boundary,
    input wire vir_pkg::vir_ctl_s ctl,
    input wire logic [7:0] data_in,
    output logic int_ack,
    output logic busy,
    output vir_pkg::vir_mem_s mem,
    output logic [15:0] pc,
    output logic [15:0] stack_top_pointer,
    output logic [7:0] vector_base,
    output logic maskable_interrupt_enable,
    output logic interrupt_enable_shadow,
    output logic [1:0] int_mode
);

    typedef enum logic [1:0] {
        VIR_IDLE = 2'b01,
        VIR_RUN = 2'b10
    } vir_state_e;

    vir_state_e state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] base_reg, base_next;
    logic ie_reg, ie_next;
    logic sh_reg, sh_next;
    logic [1:0] mode_reg, mode_next;
    logic [15:0] pc_reg, pc_next;
    logic [15:0] sp_reg, sp_next;
    logic [15:0] ptr_reg, ptr_next;
    logic [7:0] lo_reg, lo_next;
    logic ack_reg, ack_next;
    vir_pkg::vir_mem_s mem_reg, mem_next;
    logic busy_reg, busy_next;
    logic accept;
    logic [15:0] push_addr;

    function automatic vir_pkg::vir_mem_s mem_op(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
        vir_pkg::vir_mem_s m;
        m.req = 1'b1;
        m.wr = wr;
        m.addr = addr;
        m.wdata = wd;
        return m;
    endfunction : mem_op

    // Acceptance needs a request at a boundary, the primary enable set and table mode
    function automatic logic take_int(input logic req, input logic bd, input logic en, input logic [1:0] md);
        return req && bd && en && (md == vir_pkg::MODE_TABLE);
    endfunction : take_int

    // Stack grows downward; each store uses the slot below the current top
    function automatic logic [15:0] stack_dec(input logic [15:0] sp);
        return sp - 16'h0001;
    endfunction : stack_dec

    // Request decode shared by the sequencer and the enable logic
    assign accept = (state_reg == VIR_IDLE) && take_int(int_req, insn_boundary, ie_reg, mode_reg);
    assign push_addr = stack_dec(sp_reg);

    // Sequencer: state, cycle count, acknowledge and the latched table inputs
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        ptr_next = ptr_reg;
        lo_next = lo_reg;
        ack_next = 1'b0;
        unique case (state_reg)
            VIR_IDLE: begin
                if (accept) begin
                    state_next = VIR_RUN;
                    cnt_next = 5'h00;
                    busy_next = 1'b1;
                end
            end
            VIR_RUN: begin
                cnt_next = cnt_reg + 5'h01;
                // Acknowledge held through the two added wait states
                ack_next = (cnt_next >= 5'h01) && (cnt_next <= vir_pkg::VEC_SAMPLE_CNT);
                if (cnt_reg == vir_pkg::VEC_SAMPLE_CNT) begin
                    ptr_next = {base_reg, data_in[7:1], 1'b0};
                end
                if (cnt_reg == vir_pkg::READ_LO_CNT) begin
                    lo_next = data_in;
                end
                if (cnt_reg == vir_pkg::LAST_CNT) begin
                    state_next = VIR_IDLE;
                    busy_next = 1'b0;
                end
            end
            default: begin
                state_next = VIR_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= VIR_IDLE;
            cnt_reg <= 5'h00;
            busy_reg <= 1'b0;
            ptr_reg <= 16'h0000;
            lo_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            ptr_reg <= ptr_next;
            lo_reg <= lo_next;
            ack_reg <= ack_next;
        end
    end

    // Software-visible controls, taken only while idle
    always_comb begin
        base_next = base_reg;
        ie_next = ie_reg;
        sh_next = sh_reg;
        mode_next = mode_reg;
        if (state_reg == VIR_IDLE) begin
            if (ctl.load_base) begin
                base_next = ctl.base_value;
            end
            if (ctl.mode_load) begin
                mode_next = ctl.mode;
            end
            // Disable wins when both strobes arrive together
            if (ctl.disable_int) begin
                ie_next = 1'b0;
                sh_next = 1'b0;
            end else if (ctl.enable_int) begin
                ie_next = 1'b1;
                sh_next = 1'b1;
            end
        end
        // Acceptance overrides a simultaneous enable strobe
        if (accept) begin
            ie_next = 1'b0;
            sh_next = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_reg <= vir_pkg::VBASE_RESET;
            ie_reg <= 1'b0;
            sh_reg <= 1'b0;
            mode_reg <= vir_pkg::MODE_RESET;
        end else begin
            base_reg <= base_next;
            ie_reg <= ie_next;
            sh_reg <= sh_next;
            mode_reg <= mode_next;
        end
    end

    // Program counter, stack and the memory transfers of the response
    always_comb begin
        pc_next = pc_reg;
        sp_next = sp_reg;
        mem_next = '0;
        if (state_reg == VIR_IDLE) begin
            if (ctl.pc_load) begin
                pc_next = ctl.pc_value;
            end
        end else if (state_reg == VIR_RUN) begin
            if (cnt_next == vir_pkg::PUSH_HI_CNT) begin
                sp_next = push_addr;
                mem_next = mem_op(1'b1, push_addr, pc_reg[15:8]);
            end
            if (cnt_next == vir_pkg::PUSH_LO_CNT) begin
                sp_next = push_addr;
                mem_next = mem_op(1'b1, push_addr, pc_reg[7:0]);
            end
            if (cnt_next == vir_pkg::READ_LO_CNT) begin
                mem_next = mem_op(1'b0, ptr_reg, 8'h00);
            end
            if (cnt_next == vir_pkg::READ_HI_CNT) begin
                mem_next = mem_op(1'b0, ptr_reg + 16'h0001, 8'h00);
            end
            if (cnt_reg == vir_pkg::LAST_CNT) begin
                pc_next = {data_in, lo_reg};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc_reg <= vir_pkg::PC_RESET;
            sp_reg <= vir_pkg::SP_RESET;
            mem_reg <= '0;
        end else begin
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            mem_reg <= mem_next;
        end
    end

    assign int_ack = ack_reg;
    assign busy = busy_reg;
    assign mem = mem_reg;
    assign pc = pc_reg;
    assign stack_top_pointer = sp_reg;
    assign vector_base = base_reg;
    assign maskable_interrupt_enable = ie_reg;
    assign interrupt_enable_shadow = sh_reg;
    assign int_mode = mode_reg;

endmodule : vir_response

// ### verification/vir_assertions.sv
`timescale 1ns/1ps
module vir_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic int_ack,
    input wire logic busy,
    input wire vir_pkg::vir_mem_s mem,
    input wire logic [15:0] pc,
    input wire logic [15:0] stack_top_pointer,
    input wire logic [7:0] vector_base,
    input wire logic maskable_interrupt_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_enable_cleared: assert property ($rose(busy) |-> !maskable_interrupt_enable) else $error("enable");
    a_refuse_off: assert property (!busy && !maskable_interrupt_enable |=> !busy) else $error("taken");
    a_ack_waits: assert property ($rose(busy) |-> ##1 int_ack[*5] ##1 !int_ack) else $error("ack");
    a_total_time: assert property ($rose(busy) |-> ##18 busy ##1 !busy) else $error("length");
    a_base_steady: assert property (busy |=> $stable(vector_base)) else $error("base");
    a_push_pc: assert property ($rose(busy) |-> ##9 mem.req && mem.wr && mem.wdata == pc[15:8]
        ##3 mem.req && mem.wr && mem.wdata == pc[7:0]) else $error("push");
    a_stack_moves: assert property ($rose(busy) |-> ##12 mem.addr == stack_top_pointer
        && stack_top_pointer == $past(stack_top_pointer, 12) - 16'h2) else $error("stack");
    a_table_read: assert property ($rose(busy) |-> ##15 mem.req && !mem.wr && mem.addr[15:8] == vector_base
        && !mem.addr[0] ##3 mem.req && !mem.wr && mem.addr == $past(mem.addr, 3) + 16'h1) else $error("table");
    cover property ($rose(busy));
    cover property ($fell(busy));
    cover property (!busy && !maskable_interrupt_enable ##1 !busy);
endmodule : vir_checker
bind vir_response vir_checker chk_u (.*);

// ### verification/vir_periph.sv
`timescale 1ns/1ps
module vir_periph (
    input wire logic clock,
    input wire logic int_ack,
    input wire vir_pkg::vir_mem_s mem,
    input wire logic [7:0] vec,
    output logic [7:0] data_in
);
    logic [7:0] last = 8'h00;
    logic held = 1'b0;
    always_ff @(posedge clock) held <= mem.req && !mem.wr;
    // Table contents depend on both pointer halves so the base byte is visible in the jump target
    function automatic logic [7:0] table_byte(input logic [15:0] a);
        return a[15:8] + a[7:0] + 8'h11;
    endfunction : table_byte
    always_ff @(posedge clock) last <= table_byte(mem.addr);
    // Vector while acknowledging, table byte during a read and the cycle after, the complement of the previous cycle's table byte otherwise
    assign data_in = int_ack ? {vec[7:1], 1'b0} :
        (mem.req && !mem.wr) ? table_byte(mem.addr) : (held ? last : ~last);
endmodule : vir_periph

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0, rst = 1'b1, int_req = 1'b0, insn_boundary = 1'b0;
    logic [7:0] vec = 8'h00, data_in, vector_base;
    vir_pkg::vir_ctl_s ctl = '0;
    logic int_ack, busy, maskable_interrupt_enable, interrupt_enable_shadow;
    logic [15:0] pc, stack_top_pointer;
    logic [1:0] int_mode;
    vir_pkg::vir_mem_s mem;
    int errors = 0, comparisons = 0;
    vir_response dut_u (.*);
    vir_periph peer_u (.*);
    initial forever #25 clock = ~clock;
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        errors += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %s expected %h seen %h", what, exp, seen);
    endtask : chk
    task automatic close_out();
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic fire(logic e, logic [1:0] m, logic bd, logic [7:0] b, output int n);
        @(posedge clock) ctl <= '{1'b1, b, e, !e, m, 1'b1, 1'b1, 16'h1234};
        @(posedge clock) ctl <= '0;
        int_req <= 1'b1;
        insn_boundary <= bd;
        n = 0;
        repeat (25) begin
            @(posedge clock);
            #1 n += int'(busy === 1'b1);
        end
        @(posedge clock) int_req <= 1'b0;
    endtask : fire
    task automatic refused(logic e, logic [1:0] m, logic bd);
        int n;
        fire(e, m, bd, 8'h40, n);
        chk("refused", 16'(n), 16'h0);
        chk("refused pc", pc, 16'h1234);
        chk("refused enable", {15'h0000, maskable_interrupt_enable}, {15'h0000, e});
        chk("refused mode", {14'h0000, int_mode}, {14'h0000, m});
    endtask : refused
    task automatic served(logic [7:0] b, logic [7:0] v, logic [15:0] sp);
        int n;
        vec <= v;
        fire(1'b1, vir_pkg::MODE_TABLE, 1'b1, b, n);
        chk("cycles", 16'(n), 16'(vir_pkg::TOTAL_CYCLES));
        chk("pc", pc, {b + v + 8'h12, b + v + 8'h11});
        chk("sp", stack_top_pointer, sp);
        chk("enables", {14'h0000, maskable_interrupt_enable, interrupt_enable_shadow}, 16'h0000);
        chk("base kept", {8'h00, vector_base}, {8'h00, b});
    endtask : served
    task automatic reset_mid();
        @(posedge clock) ctl <= '{1'b1, 8'h3c, 1'b1, 1'b0, vir_pkg::MODE_TABLE, 1'b1, 1'b1, 16'h1234};
        @(posedge clock) ctl <= '0;
        int_req <= 1'b1;
        insn_boundary <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk("mid busy", {15'h0000, busy}, 16'h0001);
        @(posedge clock) rst <= 1'b1;
        int_req <= 1'b0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        #1 chk("reset base", {8'h00, vector_base}, {8'h00, vir_pkg::VBASE_RESET});
        chk("reset busy", {15'h0000, busy}, 16'h0000);
        chk("reset sp", stack_top_pointer, vir_pkg::SP_RESET);
        chk("reset enables", {14'h0000, maskable_interrupt_enable, interrupt_enable_shadow}, 16'h0000);
    endtask : reset_mid
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        #1 chk("base", {8'h00, vector_base}, {8'h00, vir_pkg::VBASE_RESET});
        refused(1'b0, vir_pkg::MODE_TABLE, 1'b1);
        refused(1'b1, vir_pkg::MODE_TABLE, 1'b0);
        refused(1'b1, 2'h1, 1'b1);
        served(8'h00, 8'h00, 16'hfffd);
        served(8'ha5, 8'hfe, 16'hfffb);
        reset_mid();
        served(8'h7e, 8'h02, 16'hfffd);
        close_out();
    end
    initial #100000 begin
        errors++;
        close_out();
    end
endmodule : tb
